// *** logic/spkd_sequencer.sv ***
// Purpose: Diagnostic sequencer of a four-channel bridge amplifier
// Assumes: Bus slave delivers instruction bytes and read strobes on clock
// Notes:   Analog comparator levels arrive from pins and are synchronised
`include "spkd_consts.svh"
`default_nettype none
module spkd_sequencer #(
  parameter int ACQ_CYCLES   = `SPKD_ACQ_CYCLES,
  parameter int CHECK_CYCLES = `SPKD_CHECK_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       hostWrite,
  input  wire logic [7:0] firstInstructionByte,
  input  wire logic [7:0] secondInstructionByte,
  input  wire logic       hostRead,
  input  wire logic [3:0] shortGndPin,
  input  wire logic [3:0] shortVsPin,
  input  wire logic [3:0] shortLoadPin,
  input  wire logic [3:0] openLoadPin,
  input  wire logic [3:0] overloadPin,
  input  wire logic [3:0] offsetPin,
  input  wire logic [3:0] currentPulsePin,
  output logic            stageStandby,
  output logic            testPulseOn,
  output logic [3:0]      channelOff,
  output logic [3:0]      lineDriverSel,
  output logic            unmuteFront,
  output logic            unmuteRear,
  output logic            clipTenPercent,
  output logic            fastMute,
  output logic            diagEnabled,
  output logic [7:0]      firstDiagnosticByte,
  output logic [7:0]      secondDiagnosticByte,
  output logic [7:0]      thirdDiagnosticByte,
  output logic [7:0]      fourthDiagnosticByte
);
  import spkd_pkg::*;

  localparam int NCH = 4;
  localparam int NPIN = 7 * NCH;

  logic [NPIN-1:0]  pinsA_q;
  logic [NPIN-1:0]  pinsB_q;
  logic [NCH-1:0]   pulseOld_q;
  logic [7:0]       ib1_q;
  logic [7:0]       ib2_q;
  logic             pulseArm_q;
  logic             turnOnGo_q;
  logic             offStart_q;
  logic             acStart_q;
  logic             stageStandby_q;
  logic             testPulseOn_q;
  logic [NCH-1:0]   channelOff_q;
  logic [NCH-1:0]   lineDriverSel_q;
  logic [7:0]       diag0_q;
  logic [7:0]       diag1_q;
  logic [7:0]       diag2_q;
  logic [7:0]       diag3_q;

  logic [NCH-1:0]   sGnd;
  logic [NCH-1:0]   sVs;
  logic [NCH-1:0]   sLoad;
  logic [NCH-1:0]   sOpen;
  logic [NCH-1:0]   sOver;
  logic [NCH-1:0]   sOffset;
  logic [NCH-1:0]   sPulse;
  logic [NCH-1:0]   pulseRise;
  logic [NCH-1:0]   busy;
  logic [NCH-1:0]   shut;
  logic [NCH-1:0]   done;
  spkd_state_type   chState [NCH];
  spkd_report_type  chReport [NCH];

  logic             standbyOffNow;
  logic             diagEnNow;
  logic             turnOnReq;
  logic             offsetRise;
  logic             acRise;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pinsA_q    <= '0;
      pinsB_q    <= '0;
      pulseOld_q <= '0;
    end else begin
      pinsA_q    <= {currentPulsePin, offsetPin, overloadPin, openLoadPin,
                     shortLoadPin, shortVsPin, shortGndPin};
      pinsB_q    <= pinsA_q;
      pulseOld_q <= sPulse;
    end
  end

  assign sGnd      = pinsB_q[0*NCH +: NCH];
  assign sVs       = pinsB_q[1*NCH +: NCH];
  assign sLoad     = pinsB_q[2*NCH +: NCH];
  assign sOpen     = pinsB_q[3*NCH +: NCH];
  assign sOver     = pinsB_q[4*NCH +: NCH];
  assign sOffset   = pinsB_q[5*NCH +: NCH];
  assign sPulse    = pinsB_q[6*NCH +: NCH];
  assign pulseRise = sPulse & ~pulseOld_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction bytes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ib1_q <= `SPKD_BYTE_RESET;
      ib2_q <= `SPKD_BYTE_RESET;
    end else if (hostWrite) begin
      ib1_q <= firstInstructionByte;
      ib2_q <= secondInstructionByte;
    end
  end

  assign standbyOffNow = hostWrite ? secondInstructionByte[`SPKD_IB2_STANDBY_OFF]
                                   : ib2_q[`SPKD_IB2_STANDBY_OFF];
  assign diagEnNow     = firstInstructionByte[`SPKD_IB1_DIAG_EN];
  assign turnOnReq     = hostWrite && pulseArm_q && diagEnNow
                         && secondInstructionByte[`SPKD_IB2_STANDBY_OFF]
                         && !ib2_q[`SPKD_IB2_STANDBY_OFF];
  assign offsetRise    = hostWrite && firstInstructionByte[`SPKD_IB1_OFFSET_EN]
                         && !ib1_q[`SPKD_IB1_OFFSET_EN];
  assign acRise        = hostWrite && secondInstructionByte[`SPKD_IB2_AC_EN]
                         && !ib2_q[`SPKD_IB2_AC_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Request strobes to the channels
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pulseArm_q <= 1'b1;
      turnOnGo_q <= 1'b0;
      offStart_q <= 1'b0;
      acStart_q  <= 1'b0;
    end else begin
      if (hostRead) pulseArm_q <= 1'b1;
      else if (turnOnReq) pulseArm_q <= 1'b0;
      turnOnGo_q <= turnOnReq;
      offStart_q <= hostRead || offsetRise;
      acStart_q  <= hostRead || acRise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel sequencers
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      spkd_channel #(
        .ACQ_CYCLES   (ACQ_CYCLES),
        .CHECK_CYCLES (CHECK_CYCLES)
      ) u_channel (
        .clock        (clock),
        .reset_n      (reset_n),
        .diagEnable   (ib1_q[`SPKD_IB1_DIAG_EN]),
        .turnOnStart  (turnOnGo_q),
        .rearm        (hostRead),
        .offsetStart  (offStart_q),
        .acStart      (acStart_q),
        .offsetEnable (ib1_q[`SPKD_IB1_OFFSET_EN]),
        .acEnable     (ib2_q[`SPKD_IB2_AC_EN]),
        .shortGnd     (sGnd[ch]),
        .shortVs      (sVs[ch]),
        .shortLoad    (sLoad[ch]),
        .openLoad     (sOpen[ch]),
        .overload     (sOver[ch]),
        .offsetHigh   (sOffset[ch]),
        .currentPulse (pulseRise[ch]),
        .chanState    (chState[ch]),
        .cycleDone    (done[ch]),
        .report       (chReport[ch])
      );
      assign busy[ch] = (chState[ch] == SPKD_TURNON);
      assign shut[ch] = (chState[ch] == SPKD_CHECK) || (chState[ch] == SPKD_DIAG)
                        || (chState[ch] == SPKD_RESTART);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power stage control
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stageStandby_q <= 1'b1;
      testPulseOn_q  <= 1'b0;
      channelOff_q   <= '0;
    end else begin
      stageStandby_q <= !standbyOffNow || turnOnReq || turnOnGo_q || (|busy);
      testPulseOn_q  <= |busy;
      channelOff_q   <= shut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold selection per channel
  genvar th;
  generate
    for (th = 0; th < NCH; th++) begin : g_thr
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          lineDriverSel_q[th] <= 1'b0;
        end else begin
          lineDriverSel_q[th] <= ib2_q[`SPKD_IB2_LINE_DRV]
                                 && ((th < 2) ? ib1_q[`SPKD_IB1_GAIN_FRONT]
                                              : ib1_q[`SPKD_IB1_GAIN_REAR]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic bytes, snapshot at each read before re-arm
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      diag0_q <= `SPKD_BYTE_RESET;
      diag1_q <= `SPKD_BYTE_RESET;
      diag2_q <= `SPKD_BYTE_RESET;
      diag3_q <= `SPKD_BYTE_RESET;
    end else if (hostRead) begin
      diag0_q <= {1'b0, |done, chReport[0]};
      diag1_q <= {ib1_q[`SPKD_IB1_OFFSET_EN], ib2_q[`SPKD_IB2_AC_EN], chReport[1]};
      diag2_q <= {2'b00, chReport[2]};
      diag3_q <= {2'b00, chReport[3]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign stageStandby         = stageStandby_q;
  assign testPulseOn          = testPulseOn_q;
  assign channelOff           = channelOff_q;
  assign lineDriverSel        = lineDriverSel_q;
  assign unmuteFront          = ib1_q[`SPKD_IB1_UNMUTE_FR];
  assign unmuteRear           = ib1_q[`SPKD_IB1_UNMUTE_RE];
  assign clipTenPercent       = ib1_q[`SPKD_IB1_CLIP_SEL];
  assign fastMute             = ib2_q[`SPKD_IB2_FAST_MUTE];
  assign diagEnabled          = ib1_q[`SPKD_IB1_DIAG_EN];
  assign firstDiagnosticByte  = diag0_q;
  assign secondDiagnosticByte = diag1_q;
  assign thirdDiagnosticByte  = diag2_q;
  assign fourthDiagnosticByte = diag3_q;
endmodule
`default_nettype wire

// *** pkg/spkd_consts.svh ***
// Purpose: Shared constants of the speaker diagnostic sequencer
// Assumes: 100 MHz clock, instruction and diagnostic bit positions below
// Notes:   Timing counts derive from times in ms and the clock rate
//
// How it works
// - On bus request at standby exit, run turn-on pulse test; hold result until re-requested.
// - Standby exit plus diag enable together: test pulse first, stage kept in standby.
// - After turn-on, permanent diagnostic runs; turn-on result kept until a short appears.
// - Status latched at end of pulse top; acquisition lasts 100 ms.
// - Line-driver thresholds only with 16 dB gain and line-driver select set.
// - Diagnostics off: restart mode, faulty channel off, rechecked every 1 ms.
// - Diagnostic mode enabled by bus write, self-starts on channel overload.
// - Overload in diagnostic mode: recheck after 1 ms, reactivate if gone.
// - Overload still present at recheck: run 100 ms diagnostic cycle on channel.
// - After cycle, channel to restart mode, result stored, next cycle armed by read.
// - Offset detection enabled: flag channel whose DC offset exceeds 2 V.
// - Offset window opens at previous read or enable set, closes at read.
// - Overload during test suspends offset and AC diagnostics.
// - Tweeter confirmed only with at least 3 current pulses above 500 mA.
// - Several faults: one reported first, others on later cycles, by priority.
// - Permanent diagnostic never reports open load.
// - A fault is reported only if stable over the whole measurement period.
// - Every read re-arms all cycle types and returns previous cycle results.
// - Fast-mute bit cuts muting time below 1.5 ms; host clears it later.
// - First instruction byte bit 6 enables diagnostics when set.
// - First diagnostic byte bit 6 is set once a diagnostic cycle terminated.
`ifndef SPKD_CONSTS_SVH
`define SPKD_CONSTS_SVH

`define SPKD_CLOCK_MHZ       100
`define SPKD_ACQ_TIME_MS     100
`define SPKD_CHECK_TIME_MS   1
`define SPKD_ACQ_CYCLES      (`SPKD_ACQ_TIME_MS * 1000 * `SPKD_CLOCK_MHZ)
`define SPKD_CHECK_CYCLES    (`SPKD_CHECK_TIME_MS * 1000 * `SPKD_CLOCK_MHZ)
`define SPKD_AC_MIN_PULSES   3
`define SPKD_BYTE_RESET      8'h00

`define SPKD_IB1_DIAG_EN     6
`define SPKD_IB1_OFFSET_EN   5
`define SPKD_IB1_GAIN_FRONT  4
`define SPKD_IB1_GAIN_REAR   3
`define SPKD_IB1_UNMUTE_FR   2
`define SPKD_IB1_UNMUTE_RE   1
`define SPKD_IB1_CLIP_SEL    0
`define SPKD_IB2_FAST_MUTE   5
`define SPKD_IB2_STANDBY_OFF 4
`define SPKD_IB2_LINE_DRV    3
`define SPKD_IB2_AC_EN       2

`define SPKD_DB_DONE         6
`define SPKD_DB_OFFSET_ACT   7
`define SPKD_DB_AC_ACT       6

`endif

// *** pkg/spkd_pkg.sv ***
// Purpose: Types of the speaker diagnostic sequencer
// Assumes: Nothing beyond the constants header
// Notes:   Channel states are Gray coded along the usual path
`default_nettype none
package spkd_pkg;
  typedef enum logic [2:0] {
    SPKD_IDLE    = 3'h0,
    SPKD_TURNON  = 3'h1,
    SPKD_PLAY    = 3'h3,
    SPKD_CHECK   = 3'h2,
    SPKD_DIAG    = 3'h6,
    SPKD_RESTART = 3'h7
  } spkd_state_type;
  typedef logic [5:0] spkd_report_type;
endpackage
`default_nettype wire

// *** logic/spkd_channel.sv ***
// Purpose: One audio channel of the diagnostic sequencer
// Assumes: Fault inputs already synchronised to clock
// Notes:   Report bits: tweeter, permanent, short load, open/offset, Vs, GND
`include "spkd_consts.svh"
`default_nettype none
module spkd_channel #(
  parameter int ACQ_CYCLES   = `SPKD_ACQ_CYCLES,
  parameter int CHECK_CYCLES = `SPKD_CHECK_CYCLES,
  parameter int CNT_W        = 24
) (
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire logic                     diagEnable,
  input  wire logic                     turnOnStart,
  input  wire logic                     rearm,
  input  wire logic                     offsetStart,
  input  wire logic                     acStart,
  input  wire logic                     offsetEnable,
  input  wire logic                     acEnable,
  input  wire logic                     shortGnd,
  input  wire logic                     shortVs,
  input  wire logic                     shortLoad,
  input  wire logic                     openLoad,
  input  wire logic                     overload,
  input  wire logic                     offsetHigh,
  input  wire logic                     currentPulse,
  output spkd_pkg::spkd_state_type      chanState,
  output logic                          cycleDone,
  output spkd_pkg::spkd_report_type     report
);
  import spkd_pkg::*;

  spkd_state_type   state_q;
  logic [CNT_W-1:0] count_q;
  logic [3:0]       acc_q;
  logic [3:0]       rec_q;
  logic             perm_q;
  logic             armed_q;
  logic             done_q;
  logic             offAcc_q;
  logic             offSusp_q;
  logic [1:0]       acCnt_q;
  logic             acSusp_q;
  logic             timerEnd;
  logic             turnOnEnd;
  logic             diagEnd;
  logic [3:0]       nowFault;
  logic             offsetFlag;
  logic             openTweeter;

  // Double-fault priority: GND with Vs both, else Vs, GND, load, open
  function automatic logic [3:0] pickFault(input logic [3:0] f);
    logic [3:0] r;
    r = 4'h0;
    if (f[0] && f[1]) r = 4'h3;
    else if (f[1]) r = 4'h2;
    else if (f[0]) r = 4'h1;
    else if (f[2]) r = 4'h4;
    else if (f[3]) r = 4'h8;
    return r;
  endfunction

  assign timerEnd  = (count_q == '0);
  assign turnOnEnd = (state_q == SPKD_TURNON) && timerEnd;
  assign diagEnd   = (state_q == SPKD_DIAG) && timerEnd;
  assign nowFault  = {openLoad && (state_q == SPKD_TURNON), shortLoad, shortVs, shortGnd};

  ////////////////////////////////////////////////////////////////////////////
  // Channel sequence
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= SPKD_IDLE;
      count_q <= '0;
    end else begin
      case (state_q)
        SPKD_IDLE: begin
          if (turnOnStart) begin
            state_q <= SPKD_TURNON;
            count_q <= CNT_W'(ACQ_CYCLES - 1);
          end
        end
        SPKD_TURNON: begin
          if (timerEnd) state_q <= SPKD_PLAY;
          else count_q <= count_q - 1'b1;
        end
        SPKD_PLAY: begin
          if (turnOnStart) begin
            state_q <= SPKD_TURNON;
            count_q <= CNT_W'(ACQ_CYCLES - 1);
          end else if (overload) begin
            state_q <= (diagEnable && armed_q) ? SPKD_CHECK : SPKD_RESTART;
            count_q <= CNT_W'(CHECK_CYCLES - 1);
          end
        end
        SPKD_CHECK: begin
          if (!timerEnd) count_q <= count_q - 1'b1;
          else if (overload) begin
            state_q <= SPKD_DIAG;
            count_q <= CNT_W'(ACQ_CYCLES - 1);
          end else state_q <= SPKD_PLAY;
        end
        SPKD_DIAG: begin
          if (!timerEnd) count_q <= count_q - 1'b1;
          else begin
            state_q <= SPKD_RESTART;
            count_q <= CNT_W'(CHECK_CYCLES - 1);
          end
        end
        SPKD_RESTART: begin
          if (!timerEnd) count_q <= count_q - 1'b1;
          else if (overload) count_q <= CNT_W'(CHECK_CYCLES - 1);
          else state_q <= SPKD_PLAY;
        end
        default: state_q <= SPKD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stable fault capture and record
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      acc_q  <= 4'hf;
      rec_q  <= 4'h0;
      perm_q <= 1'b0;
    end else begin
      if ((state_q == SPKD_TURNON) || (state_q == SPKD_DIAG)) acc_q <= acc_q & nowFault;
      else acc_q <= 4'hf;
      if (turnOnEnd) begin
        rec_q  <= pickFault(acc_q & nowFault);
        perm_q <= 1'b0;
      end else if (diagEnd) begin
        rec_q  <= pickFault(acc_q & nowFault & 4'h7);
        perm_q <= 1'b1;
      end else if (rearm && perm_q && (state_q == SPKD_PLAY)) begin
        rec_q  <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arming and done flag, cycle end wins over read
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      armed_q <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      if (diagEnd) armed_q <= 1'b0;
      else if (rearm) armed_q <= 1'b1;
      if (turnOnEnd || diagEnd) done_q <= 1'b1;
      else if (rearm) done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset and AC windows
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      offAcc_q  <= 1'b0;
      offSusp_q <= 1'b0;
      acCnt_q   <= 2'h0;
      acSusp_q  <= 1'b0;
    end else begin
      if (offsetStart) begin
        offAcc_q  <= 1'b1;
        offSusp_q <= 1'b0;
      end else begin
        offAcc_q  <= offAcc_q & offsetHigh;
        offSusp_q <= offSusp_q | overload;
      end
      if (acStart) begin
        acCnt_q  <= 2'h0;
        acSusp_q <= 1'b0;
      end else begin
        if (currentPulse && (acCnt_q != 2'(`SPKD_AC_MIN_PULSES))) acCnt_q <= acCnt_q + 1'b1;
        acSusp_q <= acSusp_q | overload;
      end
    end
  end

  assign offsetFlag  = offsetEnable && offAcc_q && !offSusp_q;
  assign openTweeter = acEnable && !acSusp_q && (acCnt_q != 2'(`SPKD_AC_MIN_PULSES));
  assign chanState   = state_q;
  assign cycleDone   = done_q;
  assign report      = {openTweeter, perm_q, rec_q[2], rec_q[3] | offsetFlag, rec_q[1], rec_q[0]};
endmodule
`default_nettype wire

// *** verif/spkd_monitor.sv ***
// Purpose: Port checker of the speaker diagnostic sequencer
// Assumes: Synchronous active-low reset on clock
// Notes:   Bound to every spkd_sequencer
`default_nettype none
module spkd_monitor #(
  parameter int ACQ_CYCLES   = 200,
  parameter int CHECK_CYCLES = 20
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       hostWrite,
  input wire logic [7:0] firstInstructionByte,
  input wire logic [7:0] secondInstructionByte,
  input wire logic       hostRead,
  input wire logic [3:0] overloadPin,
  input wire logic       stageStandby,
  input wire logic       testPulseOn,
  input wire logic [3:0] channelOff,
  input wire logic [3:0] lineDriverSel,
  input wire logic       fastMute,
  input wire logic       diagEnabled,
  input wire logic [7:0] firstDiagnosticByte,
  input wire logic [7:0] secondDiagnosticByte,
  input wire logic [7:0] thirdDiagnosticByte,
  input wire logic [7:0] fourthDiagnosticByte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  int unsigned pulseLen_q;
  ////////////////////////////////////////////////////////////////////////////
  // Length of the test pulse
  always_ff @(posedge clock) begin
    if (!reset_n || !testPulseOn) pulseLen_q <= 0;
    else pulseLen_q <= pulseLen_q + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_fast_mute_take: assert property (hostWrite |=> fastMute == $past(secondInstructionByte[5]))
    else $error("fast mute not taken from write");
  a_diag_en_take: assert property (hostWrite |=> diagEnabled == $past(firstInstructionByte[6]))
    else $error("diag enable not taken from write");
  a_hold_no_write: assert property (!hostWrite |=> $stable({diagEnabled, fastMute}))
    else $error("instruction bits moved without write");
  a_pulse_in_standby: assert property (testPulseOn |-> stageStandby)
    else $error("test pulse outside standby");
  a_pulse_length: assert property (pulseLen_q <= ACQ_CYCLES + 4)
    else $error("test pulse too long");
  a_report_stands: assert property (!hostRead |=> $stable({firstDiagnosticByte, secondDiagnosticByte,
    thirdDiagnosticByte, fourthDiagnosticByte})) else $error("report moved without read");
  a_line_drv_sel: assert property (hostWrite |-> ##2 lineDriverSel ==
    {{2{$past(firstInstructionByte[3], 2) & $past(secondInstructionByte[3], 2)}},
     {2{$past(firstInstructionByte[4], 2) & $past(secondInstructionByte[3], 2)}}})
    else $error("line driver select wrong");
  a_done_after_read: assert property ($rose(firstDiagnosticByte[6]) |-> $past(hostRead))
    else $error("done flag rose without read");
  a_off_min_time: assert property ($rose(channelOff[0]) |-> channelOff[0] [*8])
    else $error("channel back before recheck");
  a_off_cause: assert property ($rose(channelOff[1]) |-> $past(overloadPin[1], 2) ||
    $past(overloadPin[1], 3) || $past(overloadPin[1], 4) || $past(overloadPin[1], 5))
    else $error("channel off without overload");
  c_pulse: cover property ($rose(testPulseOn));
  c_diag_off: cover property ($rose(channelOff[2]));
  c_done: cover property ($rose(firstDiagnosticByte[6]));
endmodule
bind spkd_sequencer spkd_monitor #(.ACQ_CYCLES(ACQ_CYCLES), .CHECK_CYCLES(CHECK_CYCLES)) mon_u (
  .clock, .reset_n, .hostWrite, .firstInstructionByte, .secondInstructionByte, .hostRead, .overloadPin,
  .stageStandby, .testPulseOn, .channelOff, .lineDriverSel, .fastMute, .diagEnabled,
  .firstDiagnosticByte, .secondDiagnosticByte, .thirdDiagnosticByte, .fourthDiagnosticByte);
`default_nettype wire

// *** verif/spkd_host_model.sv ***
// Purpose: Host side: instruction writes and result reads
// Assumes: Strobes last one clock
// Notes:   Bytes scrambled outside a write
`default_nettype none
module spkd_host_model (
  input  wire logic       clock,
  output logic            hostWrite,
  output logic [7:0]      firstInstructionByte,
  output logic [7:0]      secondInstructionByte,
  output logic            hostRead
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hostWrite = 1'h0;
    hostRead = 1'h0;
    firstInstructionByte = 8'h00;
    secondInstructionByte = 8'h00;
  end
  task automatic do_write(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clock);
    hostWrite <= 1'h1;
    firstInstructionByte <= b1;
    secondInstructionByte <= b2;
    @(posedge clock);
    hostWrite <= 1'h0;
    firstInstructionByte <= ~b1;
    secondInstructionByte <= ~b2;
  endtask
  task automatic do_read();
    @(posedge clock);
    hostRead <= 1'h1;
    @(posedge clock);
    hostRead <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** verif/spkd_sequencer_tb.sv ***
// Purpose: Self-checking bench of the speaker diagnostic sequencer
// Assumes: Short acquisition and recheck counts
// Notes:   Read results checked from a queue of notes
`default_nettype none
module spkd_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACQ = 200;
  localparam int CHK = 20;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic hostWrite, hostRead, stby, tpo, ufr, ure, clip, fmute, den;
  logic [7:0] ib1, ib2, db1, db2, db3, db4, b1, b2;
  logic [3:0] sGnd = 4'h0, sVs = 4'h0, sLoad = 4'h0, oLoad = 4'h0, ovl = 4'h0, ofs = 4'h0, cur = 4'h0;
  logic [3:0] chOff, ldSel;
  logic [31:0] expQ[$], mskQ[$];
  logic rdDly = 1'h0;
  int fails = 0, n_checks = 0, k, n;
  int pc[4] = '{3, 2, 3, 0};
  always #5 clock = ~clock;
  spkd_host_model host_u (.clock(clock), .hostWrite(hostWrite), .firstInstructionByte(ib1),
    .secondInstructionByte(ib2), .hostRead(hostRead));
  spkd_sequencer #(.ACQ_CYCLES(ACQ), .CHECK_CYCLES(CHK)) dut_u (.clock(clock), .reset_n(reset_n),
    .hostWrite(hostWrite), .firstInstructionByte(ib1), .secondInstructionByte(ib2), .hostRead(hostRead),
    .shortGndPin(sGnd), .shortVsPin(sVs), .shortLoadPin(sLoad), .openLoadPin(oLoad), .overloadPin(ovl),
    .offsetPin(ofs), .currentPulsePin(cur), .stageStandby(stby), .testPulseOn(tpo), .channelOff(chOff),
    .lineDriverSel(ldSel), .unmuteFront(ufr), .unmuteRear(ure), .clipTenPercent(clip), .fastMute(fmute),
    .diagEnabled(den), .firstDiagnosticByte(db1), .secondDiagnosticByte(db2),
    .thirdDiagnosticByte(db3), .fourthDiagnosticByte(db4));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic rd(input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    host_u.do_read();
  endtask
  task automatic wait_off(input int c, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (chOff[c] !== v && cnt < lim) begin
      @(posedge clock);
      cnt++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge clock) begin
    rdDly <= hostRead;
    if (rdDly) check({db4, db3, db2, db1} & mskQ.pop_front(), expQ.pop_front(), "bytes");
  end
  initial begin
    #50us;
    fails++;
    $display("mismatch at %0t: watchdog", $time);
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'ha5f1_4140));
    cyc(20);
    reset_n <= 1'h1;
    cyc(4);
    sGnd <= 4'h3;
    sVs <= 4'h5;
    oLoad <= 4'h8;
    host_u.do_write(8'h40, 8'h10);
    #1 check({stby, den}, 2'h3, "turn-on write");
    n = 0;
    while (tpo !== 1'h1 && n < 10) begin @(posedge clock); n++; end
    cyc(ACQ / 2);
    sVs <= 4'h1;
    n = ACQ / 2;
    while (tpo === 1'h1 && n < ACQ + 10) begin @(posedge clock); n++; end
    check(n >= ACQ - 4 && n <= ACQ + 4, 1'h1, "pulse length");
    {sGnd, sVs, oLoad} <= 12'h000;
    cyc(4);
    #1 check(stby, 1'h0, "standby left");
    rd(32'h0400_0103, 32'h3F3F_FFBF);
    rd(32'h0400_0103, 32'h3F3F_FFBF);
    $display("test turn-on done");
    host_u.do_write(8'h00, 8'h10);
    ovl <= 4'h1;
    wait_off(0, 1'h1, 10, n);
    cyc(3 * CHK);
    check(chOff, 4'h1, "restart off");
    ovl <= 4'h0;
    wait_off(0, 1'h0, 3 * CHK, n);
    check(n <= CHK + 6, 1'h1, "restart back");
    $display("test restart done");
    host_u.do_write(8'h40, 8'h10);
    ovl <= 4'h2;
    cyc(3);
    ovl <= 4'h0;
    wait_off(1, 1'h1, 10, n);
    wait_off(1, 1'h0, ACQ, n);
    check(n >= CHK - 4 && n <= CHK + 4, 1'h1, "check only");
    ovl <= 4'h4;
    sVs <= 4'h4;
    oLoad <= 4'h4;
    cyc(CHK + ACQ + 20);
    check(chOff, 4'h4, "diag hold");
    {ovl, sVs, oLoad} <= 12'h000;
    wait_off(2, 1'h0, 3 * CHK, n);
    check(n <= CHK + 6, 1'h1, "back after diag");
    rd(32'h0012_0040, 32'h003F_0040);
    rd(32'h0010_0000, 32'h003F_0040);
    $display("test permanent done");
    ofs <= 4'h7;
    host_u.do_write(8'h60, 8'h10);
    ovl <= 4'h4;
    cyc(3);
    ovl <= 4'h0;
    cyc(10);
    ofs <= 4'h5;
    cyc(1);
    ofs <= 4'h7;
    cyc(40);
    rd(32'h0000_8004, 32'h0004_8404);
    ofs <= 4'h0;
    $display("test offset done");
    host_u.do_write(8'h40, 8'h14);
    pc[2] = 3 + $urandom % 4;
    for (k = 0; k < 7; k++) begin
      for (n = 0; n < 4; n++) cur[n] <= (k < pc[n]);
      cyc(4);
      cur <= 4'h0;
      cyc(4);
    end
    rd(32'h2000_6000, 32'h2020_E020);
    $display("test tweeter done");
    for (k = 0; k < 8; k++) begin
      b1 = {1'h0, 7'($urandom)};
      b2 = {2'h0, 1'($urandom), 1'h1, 2'($urandom), 2'h0};
      host_u.do_write(b1, b2);
      #1 check({den, fmute, ufr, ure, clip}, {b1[6], b2[5], b1[2:0]}, "bits");
      @(posedge clock);
      #1 check(ldSel, {{2{b1[3] & b2[3]}}, {2{b1[4] & b2[3]}}}, "line drv");
    end
    host_u.do_write(8'h00, 8'h10);
    $display("test instruction done");
    cyc(4);
    print_verdict();
  end
endmodule
`default_nettype wire
